// File: inc/dcp_consts.vh
// Constants for the channel port timing block
`ifndef DCP_CONSTS_VH
`define DCP_CONSTS_VH

// System clock period in picoseconds (100 MHz)
`define DCP_CLK_PS 32'd10000

// Lane widths
`define DCP_DQ_W 8
`define DCP_ROW_W 3
`define DCP_COL_W 5
`define DCP_ADDR_W 6
`define DCP_RDW 32

// Power states
`define DCP_ST_ATTENTION_STATE 3'h0
`define DCP_ST_STANDBY_STATE 3'h1
`define DCP_ST_NAP 3'h2
`define DCP_ST_PDN 3'h3
`define DCP_ST_NAPXA 3'h4
`define DCP_ST_NAPXB 3'h5
`define DCP_ST_PDNXA 3'h6
`define DCP_ST_PDNXB 3'h7

// Power state delays in channel cycles
`define DCP_AS_CYC 4'h2
`define DCP_SA_CYC 4'h2
`define DCP_ASN_CYC 4'h4
`define DCP_NAPXB_CNT_W 4

// Exit times as printed
`define DCP_NAPXA_NS 32'd50
`define DCP_NAPXB_NS 32'd40
`define DCP_PDNXA_US 32'd4
`define DCP_PDNXB_CYC 14'h2328

// Crossing adjustment codes
`define DCP_ADJ_NOM 2'h0
`define DCP_ADJ_SHORT 2'h1
`define DCP_ADJ_LONG 2'h2

// Latency counter width and reset latency
`define DCP_LAT_W 5
`define DCP_LAT_RST 5'h08

// Serial read word length
`define DCP_SR_W 8
`define DCP_SR_CNT_W 4

`endif

// File: rtl/dcp_channel_port.v
// Channel and serial port timing logic of the memory device
//
// Function
// - Sample lanes at both receive clock edges
// - Drive read lanes twice per transmit cycle
// - Command sampled odd rising, even falling
// - Upstream chain sampled on serial falling
// - Serial read bits launched on falling
// - Broadcast bit set: all sleepers exit
// - Broadcast clear: only addressed device exits
// - Address on lanes 5:0 at rising
// - Chain repeats downstream; back only read
// - Attention to standby in 1-4 cycles
// - Standby to attention within 3 cycles
// - Nap or power-down entry within 8
// - Nap exit phases 50 ns, 40 ns
// - Power-down exit 4 us, 9000 cycles
// - Read data crosses receive to transmit
// - Delay is latency minus phase offset
// - Delay may be one shorter or longer
// - Crossing latency chosen once at init
`timescale 1ns/1ps
`default_nettype none
`include "dcp_consts.vh"

module dcp_channel_port #(
  parameter [`DCP_ADDR_W-1:0] DEVICE_ADDR = 6'h00,
  parameter [13:0] PDNXB_CYCLES = `DCP_PDNXB_CYC,
  parameter [15:0] PDNXA_CLKS = 16'd400
) (
  input wire clock,
  input wire sys_rst,
  input wire transmit_clock,
  input wire receive_clock,
  input wire serial_clock,
  input wire serial_cmd,
  input wire [`DCP_DQ_W-1:0] data_lane_group_a_in,
  input wire [`DCP_DQ_W-1:0] data_lane_group_b_in,
  input wire [`DCP_ROW_W-1:0] row_lanes,
  input wire [`DCP_COL_W-1:0] col_lanes,
  input wire chain_upstream_pin_in,
  input wire chain_downstream_pin_in,
  input wire exit_broadcast_select,
  input wire chain_read_return,
  input wire req_standby,
  input wire req_attention,
  input wire req_nap,
  input wire req_power_down,
  input wire init_active,
  input wire [1:0] latency_adjust,
  input wire [`DCP_LAT_W-1:0] column_access_latency,
  input wire read_cmd,
  input wire [`DCP_RDW-1:0] read_data,
  input wire serial_read_start,
  input wire [`DCP_SR_W-1:0] serial_read_word,
  output reg [`DCP_DQ_W-1:0] data_lane_group_a_out,
  output reg [`DCP_DQ_W-1:0] data_lane_group_b_out,
  output reg data_lanes_oe_n,
  output reg [2*`DCP_DQ_W-1:0] sample_even,
  output reg [2*`DCP_DQ_W-1:0] sample_odd,
  output reg [`DCP_ROW_W+`DCP_COL_W-1:0] rowcol_even,
  output reg [`DCP_ROW_W+`DCP_COL_W-1:0] rowcol_odd,
  output reg sample_valid,
  output reg [1:0] cmd_pair,
  output reg cmd_pair_valid,
  output reg chain_in_bit,
  output reg chain_in_valid,
  output reg chain_upstream_pin_out,
  output reg chain_upstream_pin_oe_n,
  output reg chain_downstream_pin_out,
  output reg [2:0] power_state,
  output reg latency_locked,
  output reg read_busy
);

  // Derived cycle counts for nap exit, longest times round down
  localparam [31:0] NAPXA_RAW = (`DCP_NAPXA_NS * 32'd1000) / `DCP_CLK_PS;
  localparam [31:0] NAPXB_RAW = (`DCP_NAPXB_NS * 32'd1000) / `DCP_CLK_PS;
  localparam [15:0] NAPXA_CLKS = NAPXA_RAW[15:0];
  localparam [15:0] NAPXB_CLKS = NAPXB_RAW[15:0];
  localparam [31:0] PDNXA_RAW = (`DCP_PDNXA_US * 32'd1000000) / `DCP_CLK_PS;
  localparam AW = 3 + 3 + 2 * `DCP_DQ_W + `DCP_ROW_W + `DCP_COL_W;

  // Synchroniser: three stages for the clock, command, chain and lane inputs
  wire [AW-1:0] async_in;
  reg [AW-1:0] s1_reg;
  reg [AW-1:0] s2_reg;
  reg [AW-1:0] s3_reg;
  reg [AW-1:0] filt_reg;
  reg [AW-1:0] filt_prev_reg;
  wire [AW-1:0] filt_next;

  assign async_in = {transmit_clock, receive_clock, serial_clock, serial_cmd,
                     chain_upstream_pin_in, chain_downstream_pin_in,
                     data_lane_group_a_in, data_lane_group_b_in, row_lanes, col_lanes};

  // Filtered value follows only once stages two and three agree
  assign filt_next = (s3_reg & ~(s2_reg ^ s3_reg)) | (filt_reg & (s2_reg ^ s3_reg));

  always @(posedge clock) begin
    if (sys_rst) begin
      s1_reg <= {AW{1'b0}};
      s2_reg <= {AW{1'b0}};
      s3_reg <= {AW{1'b0}};
      filt_reg <= {AW{1'b0}};
      filt_prev_reg <= {AW{1'b0}};
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      filt_reg <= filt_next;
      filt_prev_reg <= filt_reg;
    end
  end

  // Field picks from the filtered vector
  wire tclk_f = filt_reg[AW-1];
  wire rclk_f = filt_reg[AW-2];
  wire sck_f = filt_reg[AW-3];
  wire cmd_f = filt_reg[AW-4];
  wire up_f = filt_reg[AW-5];
  wire dn_f = filt_reg[AW-6];
  wire [2*`DCP_DQ_W-1:0] dq_f = filt_reg[AW-7 -: 2*`DCP_DQ_W];
  wire [`DCP_ROW_W+`DCP_COL_W-1:0] rc_f = filt_reg[`DCP_ROW_W+`DCP_COL_W-1:0];

  // Edge strobes on the sampled clocks
  wire tclk_fall = filt_prev_reg[AW-1] & ~tclk_f;
  wire tclk_rise = ~filt_prev_reg[AW-1] & tclk_f;
  wire rclk_fall = filt_prev_reg[AW-2] & ~rclk_f;
  wire rclk_rise = ~filt_prev_reg[AW-2] & rclk_f;
  wire sck_fall = filt_prev_reg[AW-3] & ~sck_f;
  wire sck_rise = ~filt_prev_reg[AW-3] & sck_f;

  // lane sampling: falling receive edge is 0%, rising is 50%
  always @(posedge clock) begin
    if (sys_rst) begin
      sample_even <= {2*`DCP_DQ_W{1'b0}};
      sample_odd <= {2*`DCP_DQ_W{1'b0}};
      rowcol_even <= {`DCP_ROW_W+`DCP_COL_W{1'b0}};
      rowcol_odd <= {`DCP_ROW_W+`DCP_COL_W{1'b0}};
      sample_valid <= 1'b0;
    end else begin
      sample_valid <= rclk_rise;
      if (rclk_fall) begin
        sample_even <= dq_f;
        rowcol_even <= rc_f;
      end
      if (rclk_rise) begin
        sample_odd <= dq_f;
        rowcol_odd <= rc_f;
      end
    end
  end

  // command bits: odd on rising, even on falling serial edge
  reg cmd_odd_reg;
  always @(posedge clock) begin
    if (sys_rst) begin
      cmd_odd_reg <= 1'b0;
      cmd_pair <= 2'h0;
      cmd_pair_valid <= 1'b0;
    end else begin
      cmd_pair_valid <= sck_fall;
      if (sck_rise) begin
        cmd_odd_reg <= cmd_f;
      end
      if (sck_fall) begin
        cmd_pair <= {cmd_odd_reg, cmd_f};
      end
    end
  end

  // upstream chain input taken on serial falling edge only
  always @(posedge clock) begin
    if (sys_rst) begin
      chain_in_bit <= 1'b0;
      chain_in_valid <= 1'b0;
    end else begin
      chain_in_valid <= sck_fall;
      if (sck_fall) begin
        chain_in_bit <= up_f;
      end
    end
  end

  // Serial read word shifter
  reg [`DCP_SR_W-1:0] sr_reg;
  reg [`DCP_SR_CNT_W-1:0] sr_cnt_reg;
  wire sr_active = (sr_cnt_reg != {`DCP_SR_CNT_W{1'b0}});
  // One count per bit plus a closing fall that ends the drive
  localparam [31:0] SR_LOAD_RAW = `DCP_SR_W + 1;
  localparam [`DCP_SR_CNT_W-1:0] SR_LOAD = SR_LOAD_RAW[`DCP_SR_CNT_W-1:0];
  localparam [`DCP_SR_CNT_W-1:0] SR_LAST = {{(`DCP_SR_CNT_W-1){1'b0}}, 1'b1};

  // one new read bit per serial cycle on the falling edge
  always @(posedge clock) begin
    if (sys_rst) begin
      sr_reg <= {`DCP_SR_W{1'b0}};
      sr_cnt_reg <= {`DCP_SR_CNT_W{1'b0}};
    end else if (serial_read_start && !sr_active) begin
      sr_reg <= serial_read_word;
      sr_cnt_reg <= SR_LOAD;
    end else if (sck_fall && sr_active) begin
      sr_reg <= {sr_reg[`DCP_SR_W-2:0], 1'b0};
      sr_cnt_reg <= sr_cnt_reg - 1'b1;
    end
  end

  // chain repeater; upstream pin carries downstream data only on reads
  always @(posedge clock) begin
    if (sys_rst) begin
      chain_downstream_pin_out <= 1'b0;
      chain_upstream_pin_out <= 1'b0;
      chain_upstream_pin_oe_n <= 1'b1;
    end else begin
      chain_downstream_pin_out <= up_f;
      if (sr_active) begin
        // launch the next bit; the last one stands to the closing fall
        if (sck_fall && sr_cnt_reg != SR_LAST) begin
          chain_upstream_pin_out <= sr_reg[`DCP_SR_W-1];
        end
        chain_upstream_pin_oe_n <= 1'b0;
      end else if (chain_read_return) begin
        chain_upstream_pin_out <= dn_f;
        chain_upstream_pin_oe_n <= 1'b0;
      end else begin
        chain_upstream_pin_out <= 1'b0;
        chain_upstream_pin_oe_n <= 1'b1;
      end
    end
  end

  // Exit request: command high at rising serial edge while asleep
  wire asleep = (power_state == `DCP_ST_NAP) || (power_state == `DCP_ST_PDN);
  // compare captured lanes 5:0 with own address
  wire addr_hit = (dq_f[2*`DCP_DQ_W-1 -: `DCP_DQ_W] & 8'h3f) == {2'h0, DEVICE_ADDR};
  wire exit_go = sck_rise && cmd_f && asleep && (exit_broadcast_select || addr_hit);

  // Power state machine with channel-cycle and clock counters
  reg [2:0] ps_next;
  reg [13:0] cyc_reg;
  reg [15:0] clk_reg;
  reg [1:0] pend_reg;
  localparam [1:0] PEND_NONE = 2'h0;
  localparam [1:0] PEND_NAP = 2'h1;
  localparam [1:0] PEND_PDN = 2'h2;
  localparam [1:0] PEND_STANDBY_STATE = 2'h3;

  always @* begin
    ps_next = power_state;
    case (power_state)
      `DCP_ST_ATTENTION_STATE: begin
        if (pend_reg == PEND_STANDBY_STATE && cyc_reg[3:0] == `DCP_AS_CYC) begin
          ps_next = `DCP_ST_STANDBY_STATE;
        end else if (pend_reg == PEND_NAP && cyc_reg[3:0] == `DCP_ASN_CYC) begin
          ps_next = `DCP_ST_NAP;
        end else if (pend_reg == PEND_PDN && cyc_reg[3:0] == `DCP_ASN_CYC) begin
          ps_next = `DCP_ST_PDN;
        end
      end
      `DCP_ST_STANDBY_STATE: begin
        if (pend_reg == PEND_STANDBY_STATE && cyc_reg[3:0] == `DCP_SA_CYC) begin
          ps_next = `DCP_ST_ATTENTION_STATE;
        end else if (pend_reg == PEND_NAP && cyc_reg[3:0] == `DCP_ASN_CYC) begin
          ps_next = `DCP_ST_NAP;
        end else if (pend_reg == PEND_PDN && cyc_reg[3:0] == `DCP_ASN_CYC) begin
          ps_next = `DCP_ST_PDN;
        end
      end
      `DCP_ST_NAP: begin
        if (exit_go) ps_next = `DCP_ST_NAPXA;
      end
      `DCP_ST_PDN: begin
        if (exit_go) ps_next = `DCP_ST_PDNXA;
      end
      `DCP_ST_NAPXA: begin
        if (clk_reg == NAPXA_CLKS - 16'h0001) ps_next = `DCP_ST_NAPXB;
      end
      `DCP_ST_NAPXB: begin
        if (clk_reg == NAPXB_CLKS - 16'h0001) ps_next = `DCP_ST_ATTENTION_STATE;
      end
      `DCP_ST_PDNXA: begin
        if (clk_reg == PDNXA_CLKS - 16'h0001) ps_next = `DCP_ST_PDNXB;
      end
      `DCP_ST_PDNXB: begin
        if (cyc_reg == PDNXB_CYCLES) ps_next = `DCP_ST_ATTENTION_STATE;
      end
      default: ps_next = `DCP_ST_ATTENTION_STATE;
    endcase
  end

  // State, pending request and counters
  always @(posedge clock) begin
    if (sys_rst) begin
      power_state <= `DCP_ST_ATTENTION_STATE;
      pend_reg <= PEND_NONE;
      cyc_reg <= 14'h0000;
      clk_reg <= 16'h0000;
    end else begin
      power_state <= ps_next;
      if (ps_next != power_state) begin
        pend_reg <= PEND_NONE;
        cyc_reg <= 14'h0000;
        clk_reg <= 16'h0000;
      end else begin
        clk_reg <= clk_reg + 16'h0001;
        if (rclk_fall && (pend_reg != PEND_NONE || power_state == `DCP_ST_PDNXB)) begin
          cyc_reg <= cyc_reg + 14'h0001;
        end
        if (pend_reg == PEND_NONE && !asleep && power_state <= `DCP_ST_STANDBY_STATE) begin
          if (req_power_down) begin
            pend_reg <= PEND_PDN;
          end else if (req_nap) begin
            pend_reg <= PEND_NAP;
          end else if (req_standby && power_state == `DCP_ST_ATTENTION_STATE) begin
            pend_reg <= PEND_STANDBY_STATE;
          end else if (req_attention && power_state == `DCP_ST_STANDBY_STATE) begin
            pend_reg <= PEND_STANDBY_STATE;
          end
        end
      end
    end
  end

  // latency adjustment captured during init, then frozen
  reg [1:0] adj_reg;
  always @(posedge clock) begin
    if (sys_rst) begin
      adj_reg <= `DCP_ADJ_NOM;
      latency_locked <= 1'b0;
    end else if (!latency_locked) begin
      if (init_active) begin
        adj_reg <= latency_adjust;
      end else begin
        latency_locked <= 1'b1;
      end
    end
  end

  // launch count with the stored one-cycle adjustment
  function [`DCP_LAT_W-1:0] lat_count;
    input [`DCP_LAT_W-1:0] cac;
    input [1:0] adj;
    begin
      case (adj)
        `DCP_ADJ_SHORT: lat_count = cac - 1'b1;
        `DCP_ADJ_LONG: lat_count = cac + 1'b1;
        default: lat_count = cac;
      endcase
    end
  endfunction

  // read data held from command, launched in transmit cycles
  reg [`DCP_RDW-1:0] rd_hold_reg;
  reg [`DCP_LAT_W-1:0] lat_reg;
  reg [1:0] beat_reg;

  // count transmit falling edges; offset follows the clock phase
  always @(posedge clock) begin
    if (sys_rst) begin
      rd_hold_reg <= {`DCP_RDW{1'b0}};
      lat_reg <= `DCP_LAT_RST;
      read_busy <= 1'b0;
      beat_reg <= 2'h0;
    end else if (read_cmd && !read_busy && latency_locked) begin
      rd_hold_reg <= read_data;
      lat_reg <= lat_count(column_access_latency, adj_reg);
      read_busy <= 1'b1;
      beat_reg <= 2'h0;
    end else if (read_busy) begin
      if (tclk_fall && lat_reg != {`DCP_LAT_W{1'b0}}) begin
        lat_reg <= lat_reg - 1'b1;
      end else if (lat_reg == {`DCP_LAT_W{1'b0}} && (tclk_rise || tclk_fall)) begin
        beat_reg <= beat_reg + 2'h1;
        if (beat_reg == 2'h2) read_busy <= 1'b0;
      end
    end
  end

  // even half launched at rising transmit edge, odd at falling
  always @(posedge clock) begin
    if (sys_rst) begin
      data_lane_group_a_out <= {`DCP_DQ_W{1'b0}};
      data_lane_group_b_out <= {`DCP_DQ_W{1'b0}};
      data_lanes_oe_n <= 1'b1;
    end else if (read_busy && lat_reg == {`DCP_LAT_W{1'b0}}) begin
      if (tclk_rise && beat_reg == 2'h0) begin
        data_lane_group_a_out <= rd_hold_reg[31:24];
        data_lane_group_b_out <= rd_hold_reg[23:16];
        data_lanes_oe_n <= 1'b0;
      end else if (tclk_fall && beat_reg == 2'h1) begin
        data_lane_group_a_out <= rd_hold_reg[15:8];
        data_lane_group_b_out <= rd_hold_reg[7:0];
      end else if (beat_reg == 2'h2 && (tclk_rise || tclk_fall)) begin
        data_lanes_oe_n <= 1'b1;
      end
    end else if (!read_busy) begin
      data_lanes_oe_n <= 1'b1;
    end
  end

endmodule // dcp_channel_port
`default_nettype wire

// File: verification/dcp_monitor.sv
// Checker of the channel port timing block
`timescale 1ns/1ps
`default_nettype none
`include "dcp_consts.vh"
module dcp_monitor #(
  parameter int PDNXB_CYCLES = 10,
  parameter int PDNXA_CLKS = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic req_standby,
  input wire logic req_attention,
  input wire logic req_nap,
  input wire logic req_power_down,
  input wire logic init_active,
  input wire logic chain_upstream_pin_in,
  input wire logic chain_downstream_pin_out,
  input wire logic data_lanes_oe_n,
  input wire logic read_busy,
  input wire logic latency_locked,
  input wire logic [2:0] power_state
);
  localparam int PA_MAX = PDNXA_CLKS + 8;
  localparam int PB_MAX = PDNXB_CYCLES * 16 + 8;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // Exit phases in order, ending in attention
  sequence s_nap_exit;
    ##[1:5] power_state == `DCP_ST_NAPXB ##[1:4] power_state == `DCP_ST_ATTENTION_STATE;
  endsequence
  sequence s_pdn_exit;
    ##[1:PA_MAX] power_state == `DCP_ST_PDNXB ##[1:PB_MAX] power_state == `DCP_ST_ATTENTION_STATE;
  endsequence
  standby_state_entry_a: assert property (req_standby && power_state == `DCP_ST_ATTENTION_STATE |=>
    (power_state == `DCP_ST_ATTENTION_STATE) [*8] ##[1:60] power_state == `DCP_ST_STANDBY_STATE)
    else $error("standby entry out of window");
  attention_state_return_a: assert property (req_attention && power_state == `DCP_ST_STANDBY_STATE |->
    ##[1:52] power_state == `DCP_ST_ATTENTION_STATE) else $error("attention return late");
  nap_entry_a: assert property (req_nap && power_state <= `DCP_ST_STANDBY_STATE |->
    ##[1:132] power_state == `DCP_ST_NAP) else $error("nap entry late");
  pdn_entry_a: assert property (req_power_down && power_state <= `DCP_ST_STANDBY_STATE |->
    ##[1:132] power_state == `DCP_ST_PDN) else $error("power down entry late");
  nap_exit_a: assert property ($rose(power_state == `DCP_ST_NAPXA) |-> s_nap_exit)
    else $error("nap exit late");
  pdn_exit_a: assert property ($rose(power_state == `DCP_ST_PDNXA) |-> s_pdn_exit)
    else $error("power down exit late");
  lane_drive_a: assert property (!data_lanes_oe_n |-> read_busy)
    else $error("lanes driven while idle");
  read_frame_a: assert property ($fell(data_lanes_oe_n) |->
    (!data_lanes_oe_n) [*8] ##[1:10] data_lanes_oe_n) else $error("read frame length");
  chain_repeat_a: assert property ((!sys_rst && $stable(chain_upstream_pin_in)) [*7] |->
    chain_downstream_pin_out == chain_upstream_pin_in) else $error("chain not repeated");
  lock_rise_a: assert property ($rose(latency_locked) |-> !$past(init_active))
    else $error("lock during init");
  lock_hold_a: assert property (latency_locked |=> latency_locked)
    else $error("latency unlocked");
endmodule // dcp_monitor
bind dcp_channel_port dcp_monitor #(.PDNXB_CYCLES(PDNXB_CYCLES), .PDNXA_CLKS(PDNXA_CLKS))
  u_dcp_monitor (.clock(clock), .sys_rst(sys_rst), .req_standby(req_standby),
    .req_attention(req_attention), .req_nap(req_nap), .req_power_down(req_power_down),
    .init_active(init_active), .chain_upstream_pin_in(chain_upstream_pin_in),
    .chain_downstream_pin_out(chain_downstream_pin_out), .data_lanes_oe_n(data_lanes_oe_n),
    .read_busy(read_busy), .latency_locked(latency_locked), .power_state(power_state));
`default_nettype wire

// File: verification/dcp_ctrl_model.sv
// Controller model driving serial clock, command and chain frames
`timescale 1ns/1ps
`default_nettype none
module dcp_ctrl_model (
  input wire logic up_pin,
  output logic sck,
  output logic cmd,
  output logic sio,
  output logic [7:0] rx_word
);
  // Serial clock stands low outside frames
  initial begin
    sck = 1'b0;
    cmd = 1'b0;
    sio = 1'b0;
    rx_word = 8'h00;
  end
  task automatic frame(input int cyc, input logic [1:0] pr, input logic b);
    cmd = pr[1];
    sio = b;
    #23;
    for (int i = 0; i < cyc; i++) begin
      sck = 1'b1;
      // Read bits shift in at each rise after the first
      if (i > 0) rx_word = {rx_word[6:0], up_pin};
      #60 cmd = pr[0];
      #20 sck = 1'b0;
      #60 cmd = pr[1];
      #20;
    end
    // Released lines show the inverse level
    cmd = ~cmd;
    sio = ~sio;
  endtask
endmodule // dcp_ctrl_model
`default_nettype wire

// File: verification/tb_dcp_channel_port.sv
// Testbench for the channel port timing block
`timescale 1ns/1ps
`default_nettype none
`include "dcp_consts.vh"
module tb_dcp_channel_port;
  logic clock = 1'b0, sys_rst = 1'b1, transmit_clock = 1'b1, receive_clock = 1'b0;
  logic serial_clock, serial_cmd, chain_upstream_pin_in;
  logic [7:0] data_lane_group_a_in = 8'h00, data_lane_group_b_in = 8'h00;
  logic [2:0] row_lanes = 3'h0;
  logic [4:0] col_lanes = 5'h00;
  logic chain_downstream_pin_in = 1'b0, exit_broadcast_select = 1'b0, chain_read_return = 1'b0;
  logic req_standby = 1'b0, req_attention = 1'b0, req_nap = 1'b0, req_power_down = 1'b0;
  logic init_active = 1'b1, read_cmd = 1'b0, serial_read_start = 1'b0, lane_run = 1'b0;
  logic [1:0] latency_adjust = `DCP_ADJ_NOM;
  logic [31:0] read_data = 32'h00000000;
  logic [7:0] serial_read_word = 8'h00, data_lane_group_a_out, data_lane_group_b_out, rx_word;
  logic [15:0] sample_even, sample_odd;
  logic [7:0] rowcol_even, rowcol_odd;
  logic [1:0] cmd_pair;
  logic [2:0] power_state;
  logic data_lanes_oe_n, sample_valid, cmd_pair_valid, chain_in_bit, chain_in_valid;
  logic chain_upstream_pin_out, chain_upstream_pin_oe_n, chain_downstream_pin_out;
  logic latency_locked, read_busy;
  int miscompares = 0, tests_run = 0, txf = 0, n, n0, m, sv_n = 0, cv_n = 0, ci_n = 0;
  always #5 clock = ~clock;
  always #80 receive_clock = ~receive_clock;
  always #80 transmit_clock = ~transmit_clock;
  always @(negedge transmit_clock) txf++;
  // Counts of the one-cycle valid strobes
  always @(posedge clock) begin
    if (sample_valid === 1'b1) sv_n++;
    if (cmd_pair_valid === 1'b1) cv_n++;
    if (chain_in_valid === 1'b1) ci_n++;
  end
  // lanes change midway between sample points
  always @(receive_clock) if (lane_run) begin
    #40;
    {data_lane_group_a_in, data_lane_group_b_in, row_lanes, col_lanes} <=
      receive_clock ? 24'h5a3ce1 : 24'ha5c31e;
  end
  dcp_channel_port #(.DEVICE_ADDR(6'h15), .PDNXB_CYCLES(14'h000a), .PDNXA_CLKS(16'h0008))
    u_dcp_channel_port (.*, .column_access_latency(5'h08));
  dcp_ctrl_model u_dcp_ctrl_model (.up_pin(chain_upstream_pin_oe_n ?
    ~chain_upstream_pin_out : chain_upstream_pin_out), .sck(serial_clock),
    .cmd(serial_cmd), .sio(chain_upstream_pin_in), .rx_word(rx_word));
  task automatic report_and_stop;
    $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clock);
    #1;
  endtask
  task automatic wait_state(input logic [2:0] st, input int lim);
    n = 0;
    while (power_state !== st && n < lim) begin
      tick(1);
      n++;
    end
  endtask
  task automatic req(input logic [3:0] r);
    {req_standby, req_attention, req_nap, req_power_down} = r;
    tick(1);
    {req_standby, req_attention, req_nap, req_power_down} = 4'h0;
  endtask
  task automatic t_lanes;
    check({power_state, data_lanes_oe_n, chain_upstream_pin_oe_n, latency_locked}, 6'h06);
    lane_run = 1'b1;
    tick(40);
    check(sv_n, 2);
    check({sample_even, rowcol_even}, 24'h5a3ce1);
    check({sample_odd, rowcol_odd}, 24'ha5c31e);
    lane_run = 1'b0;
  endtask
  task automatic t_serial;
    for (int i = 0; i < 2; i++) begin
      u_dcp_ctrl_model.frame(1, i ? 2'b01 : 2'b10, ~i[0]);
      tick(8);
      check({cmd_pair, chain_in_bit}, i ? 3'b010 : 3'b101);
      check(cv_n, i + 1);
      check(ci_n, i + 1);
      check(chain_downstream_pin_out, chain_upstream_pin_in);
    end
  endtask
  task automatic t_sread;
    serial_read_word = 8'hb5;
    serial_read_start = 1'b1;
    tick(1);
    serial_read_start = 1'b0;
    tick(1);
    check(chain_upstream_pin_oe_n, 1'b0);
    u_dcp_ctrl_model.frame(9, 2'b00, 1'b0);
    tick(2);
    check({rx_word, chain_upstream_pin_oe_n}, 9'h16b);
    chain_read_return = 1'b1;
    for (int v = 0; v < 2; v++) begin
      chain_downstream_pin_in = ~v[0];
      tick(8);
      check({chain_upstream_pin_oe_n, chain_upstream_pin_out}, {1'b0, ~v[0]});
    end
    chain_read_return = 1'b0;
    tick(8);
    check(chain_upstream_pin_oe_n, 1'b1);
  endtask
  task automatic t_power;
    row_lanes = 3'h0;
    col_lanes = 5'h00;
    req(4'h8);
    wait_state(`DCP_ST_STANDBY_STATE, 80);
    check(n >= 15 && n <= 68, 1'b1);
    req(4'h4);
    wait_state(`DCP_ST_ATTENTION_STATE, 60);
    check(n <= 52, 1'b1);
    req(4'h2);
    wait_state(`DCP_ST_NAP, 140);
    check(n <= 132, 1'b1);
    data_lane_group_a_in = 8'h2a;
    u_dcp_ctrl_model.frame(1, 2'b11, 1'b0);
    tick(20);
    check(power_state, `DCP_ST_NAP);
    data_lane_group_a_in = 8'h15;
    u_dcp_ctrl_model.frame(1, 2'b11, 1'b0);
    tick(2);
    check(power_state, `DCP_ST_ATTENTION_STATE);
    req(4'h1);
    wait_state(`DCP_ST_PDN, 140);
    check(n <= 132, 1'b1);
    exit_broadcast_select = 1'b1;
    data_lane_group_a_in = 8'h2a;
    u_dcp_ctrl_model.frame(1, 2'b11, 1'b0);
    wait_state(`DCP_ST_ATTENTION_STATE, 250);
    check(power_state, `DCP_ST_ATTENTION_STATE);
  endtask
  task automatic t_read;
    latency_adjust = `DCP_ADJ_SHORT;
    tick(1);
    init_active = 1'b0;
    tick(2);
    check(latency_locked, 1'b1);
    latency_adjust = `DCP_ADJ_LONG;
    for (int k = 0; k < 2; k++) begin
      // Same transmit phase for both reads
      @(posedge transmit_clock);
      tick(1);
      read_data = 32'h11223344;
      read_cmd = 1'b1;
      tick(1);
      read_cmd = 1'b0;
      m = txf;
      read_data = 32'hdeadbeef;
      tick(2);
      read_cmd = 1'b1;
      tick(1);
      read_cmd = 1'b0;
      n = 0;
      while (data_lanes_oe_n !== 1'b0 && n < 400) begin
        tick(1);
        n++;
      end
      m = txf - m;
      check({data_lane_group_a_out, data_lane_group_b_out}, 16'h1122);
      tick(12);
      check({data_lane_group_a_out, data_lane_group_b_out}, 16'h3344);
      if (k == 0) n0 = m;
      check(k ? m == n0 : m >= 6 && m <= 7, 1'b1);
      tick(20);
      check(read_busy, 1'b0);
    end
  endtask
  // Cut a hung run short
  initial begin
    #400000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    tick(5);
    sys_rst = 1'b0;
    t_lanes;
    t_serial;
    t_sread;
    t_power;
    t_read;
    report_and_stop;
  end
endmodule // tb_dcp_channel_port
`default_nettype wire
